// File: rtl/iwd_cfg.svh
// Constants for the instruction word decoder: field positions, opcodes, timing.
// Assumes inclusion by bare name from the package and the decoder files.
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH

// ------------------------------------------------------------
// Word and field geometry
// ------------------------------------------------------------
`define IWD_WORD_W 14
`define IWD_FILE_MSB 6
`define IWD_DEST_BIT 7
`define IWD_BIT_LSB 7
`define IWD_BIT_MSB 9
`define IWD_K8_MSB 7
`define IWD_K11_MSB 10
`define IWD_K7_MSB 6
`define IWD_K5_MSB 4
`define IWD_K9_MSB 8
`define IWD_PTR_BIT 2
`define IWD_PTR_OFS_BIT 6

// ------------------------------------------------------------
// Opcode patterns (top bits or op field of the word) and indirect file addresses
// ------------------------------------------------------------
`define IWD_CLS_BYTE 2'h0
`define IWD_CLS_BIT 2'h1
`define IWD_OP_BCF 2'h0
`define IWD_OP_BSF 2'h1
`define IWD_OP_SKIP_CLR 2'h2
`define IWD_OP_SKIP_SET 2'h3
`define IWD_OP_DECSZ 4'hB
`define IWD_OP_INCSZ 4'hF
`define IWD_OP_ABS_CALL 3'h4
`define IWD_OP_ABS_JUMP 3'h5
`define IWD_OP_RELJ 5'h19
`define IWD_OP_LIT_RET 4'hD
`define IWD_OP_PAGE 7'h0F
`define IWD_OP_BANK 9'h001
`define IWD_OP_PTRINC 11'h002
`define IWD_OP_PTRMOV 7'h31
`define IWD_OP_RETURN 14'h0008
`define IWD_OP_INTEXIT 14'h0009
`define IWD_OP_ACCCALL 14'h000A
`define IWD_OP_ACCJUMP 14'h000B
`define IWD_OP_IND0 7'h00
`define IWD_OP_IND1 7'h01

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IWD_OSC_PER_CYC 2'h3
`define IWD_CYC_ONE 2'h1
`define IWD_CYC_TWO 2'h2

`endif

// File: rtl/iwd_cycle_div.sv
// Quarter-rate divider: one instruction cycle per four oscillator clocks.
// Assumes one free-running clock and an asynchronous active-low reset.
`include "iwd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module iwd_cycle_div (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Quarter-rate strobe
	output logic cyc_stb_out
);
	// Oscillator phase counter
	logic [1:0] phase_q;
	logic [1:0] phase_d;

	// Wraps after the fourth oscillator clock
	assign phase_d = (phase_q == `IWD_OSC_PER_CYC) ? 2'h0 : phase_q + 2'h1;
	assign cyc_stb_out = (phase_q == `IWD_OSC_PER_CYC);

	// ------------------------------------------------------------
	// Phase register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_d;
		end
	end
endmodule

`default_nettype wire

// File: rtl/iwd_decoder.sv
// Instruction word decoder with cycle-count timing.
// Assumes program memory presents a word with a valid strobe on core_clk_in.
// What this block does
// - Each instruction is one 14-bit word
// - Classes: byte, bit, literal-and-control layouts
// - One cycle unless call, return, branch, skip
// - Calls take two instruction cycles
// - Returns take two instruction cycles
// - Jumps, branches, skips take two cycles
// - Indirect access to program memory adds one
// - Instruction cycle equals four oscillator clocks
// - File address is 7 bits wide
// - Destination bit: 0 accumulator, 1 file
// - Don't-care bits never change the decode
// - Pointer field picks pointer zero or one
// - Named file register is always read first
// - Byte words: d bit 7, file 6:0
// - Bit words: 3-bit index, 7-bit file
`include "iwd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module iwd_decoder (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Instruction word from program memory
	input wire logic [13:0] instr_word_in,
	input wire logic instr_valid_in,
	// Pointer targets program memory, per pointer
	input wire logic [1:0] ptr_in_progmem_in,
	// Handshake back to the fetch side
	output logic instr_ready_out,
	// Decoded result
	output iwd_pkg::iwd_fields_t fields_out,
	output logic fields_valid_out,
	output logic cycle_stb_out,
	output logic busy_out
);
	// ------------------------------------------------------------
	// Instruction cycle strobe
	// ------------------------------------------------------------
	logic cyc_stb;

	// Divider shared by the whole decoder
	iwd_cycle_div u_div (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.cyc_stb_out(cyc_stb)
	);

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	wire [13:0] w = instr_word_in;
	wire [1:0] top2 = w[13:12];
	// Page-load and pointer-offset words share top bits with the file classes;
	// they are literal-and-control, so they are carved out of both here
	wire is_byte = (top2 == `IWD_CLS_BYTE) && (w[11:8] != 4'h0) &&
		(w[13:7] != `IWD_OP_PAGE);
	wire is_bit = (top2 == `IWD_CLS_BIT) && (w[13:7] != `IWD_OP_PTRMOV);
	wire [1:0] bit_op = w[11:10];
	wire [3:0] byte_op = w[11:8];
	wire [6:0] file_addr = w[`IWD_FILE_MSB:0];
	wire dest_file = w[`IWD_DEST_BIT];
	wire [2:0] bit_index = w[`IWD_BIT_MSB:`IWD_BIT_LSB];
	wire [7:0] lit8 = w[`IWD_K8_MSB:0];
	wire [10:0] lit11 = w[`IWD_K11_MSB:0];
	wire [6:0] lit7 = w[`IWD_K7_MSB:0];
	wire [4:0] lit5 = w[`IWD_K5_MSB:0];
	wire [8:0] lit9 = w[`IWD_K9_MSB:0];

	// Literal and control layouts; masks skip don't-care bits
	wire is_abs = (w[13:11] == `IWD_OP_ABS_CALL) || (w[13:11] == `IWD_OP_ABS_JUMP);
	wire is_abs_jump = (w[13:11] == `IWD_OP_ABS_JUMP);
	wire is_rel = (w[13:9] == `IWD_OP_RELJ);
	wire is_page = (w[13:7] == `IWD_OP_PAGE);
	wire is_bank = (w[13:5] == `IWD_OP_BANK);
	wire is_ptrinc = (w[13:3] == `IWD_OP_PTRINC);
	wire is_ptrmov = (w[13:7] == `IWD_OP_PTRMOV);
	wire is_lit_ret = (w[13:10] == `IWD_OP_LIT_RET);
	wire is_return = (w == `IWD_OP_RETURN);
	wire is_intexit = (w == `IWD_OP_INTEXIT);
	wire is_acccall = (w == `IWD_OP_ACCCALL);
	wire is_accjump = (w == `IWD_OP_ACCJUMP);
	wire is_general = (top2 == 2'h3) && !is_rel && !is_ptrmov && !is_lit_ret;

	// Pointer select: bit 2 for increment forms, bit 6 for offset forms
	wire ptr_sel = is_ptrinc ? w[`IWD_PTR_BIT] : w[`IWD_PTR_OFS_BIT];

	// Byte or bit word addressing the indirect port goes through a pointer;
	// a bit operation on the port pays the extra cycle just like a byte one
	wire ind_hit = (is_byte || is_bit) &&
		((file_addr == `IWD_OP_IND0) || (file_addr == `IWD_OP_IND1));
	wire ind_sel = file_addr[0];
	wire ind_slow = ind_hit && ptr_in_progmem_in[ind_sel];

	// Two-cycle classes
	wire is_call = is_abs && !is_abs_jump || is_acccall;
	wire is_ret = is_return || is_lit_ret || is_intexit;
	wire is_skip_bit = is_bit && bit_op[1];
	wire is_skip_cnt = is_byte && ((byte_op == `IWD_OP_DECSZ) || (byte_op == `IWD_OP_INCSZ));
	wire is_branch = is_abs_jump || is_rel || is_accjump || is_skip_bit || is_skip_cnt;
	wire two_cyc = is_call || is_ret || is_branch;
	wire [1:0] base_cyc = two_cyc ? `IWD_CYC_TWO : `IWD_CYC_ONE;
	wire [1:0] total_cyc = base_cyc + {1'b0, ind_slow};

	// Layout classification
	iwd_pkg::iwd_class_t cls;
	iwd_pkg::iwd_fmt_t fmt;
	assign cls = is_bit ? iwd_pkg::IWD_CLS_BIT_OP :
		(is_byte ? iwd_pkg::IWD_CLS_BYTE_OP : iwd_pkg::IWD_CLS_LIT_CTL);
	assign fmt = is_abs ? iwd_pkg::IWD_FMT_ABS :
		is_rel ? iwd_pkg::IWD_FMT_REL :
		is_page ? iwd_pkg::IWD_FMT_PAGE :
		is_bank ? iwd_pkg::IWD_FMT_BANK :
		(is_ptrinc || is_ptrmov) ? iwd_pkg::IWD_FMT_PTR :
		(is_general || is_lit_ret) ? iwd_pkg::IWD_FMT_GENERAL :
		(is_byte || is_bit) ? iwd_pkg::IWD_FMT_NONE : iwd_pkg::IWD_FMT_OPONLY;

	// Every file-naming word reads its register first
	iwd_pkg::iwd_fields_t dec;
	always_comb begin
		dec = '0;
		dec.cls = cls;
		dec.fmt = fmt;
		dec.file_addr = file_addr;
		dec.dest_file = is_byte ? dest_file : 1'b1;
		dec.bit_index = bit_index;
		dec.lit8 = lit8;
		dec.lit11 = lit11;
		dec.lit7 = lit7;
		dec.lit5 = lit5;
		dec.lit9 = lit9;
		dec.ptr_sel = ptr_sel;
		dec.uses_file = is_byte || is_bit;
		dec.cycles = total_cyc;
	end

	// ------------------------------------------------------------
	// Execution timing state machine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} iwd_st_t;
	iwd_st_t st_q;
	iwd_st_t st_d;
	logic [1:0] left_q;
	logic [1:0] left_d;
	iwd_pkg::iwd_fields_t fields_q;
	logic fv_q;

	// Take a word only at an instruction-cycle boundary when idle or finishing
	wire last = (st_q == ST_RUN) && (left_q == `IWD_CYC_ONE);
	wire can_take = cyc_stb && ((st_q == ST_IDLE) || last);
	wire take = can_take && instr_valid_in;
	assign instr_ready_out = can_take;

	// Next-state selection
	always_comb begin
		st_d = st_q;
		left_d = left_q;
		case (st_q)
			ST_IDLE: begin
				if (take) begin
					st_d = ST_RUN;
					left_d = total_cyc;
				end
			end
			ST_RUN: begin
				if (cyc_stb) begin
					if (take) begin
						left_d = total_cyc;
					end else if (last) begin
						st_d = ST_IDLE;
					end else begin
						left_d = left_q - 2'h1;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// State and remaining-cycle count
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= ST_IDLE;
			left_q <= 2'h0;
		end else begin
			st_q <= st_d;
			left_q <= left_d;
		end
	end

	// Decoded fields held for the whole instruction
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fields_q <= '0;
			fv_q <= 1'b0;
		end else begin
			fv_q <= take;
			if (take) begin
				fields_q <= dec;
			end
		end
	end

	assign fields_out = fields_q;
	assign fields_valid_out = fv_q;
	assign cycle_stb_out = cyc_stb;
	assign busy_out = (st_q == ST_RUN);
endmodule

`default_nettype wire

// File: rtl/iwd_pkg.sv
// Types shared by the instruction word decoder.
// Assumes iwd_cfg.svh on the include path.
`include "iwd_cfg.svh"

package iwd_pkg;
	// Instruction class
	typedef enum logic [1:0] {
		IWD_CLS_BYTE_OP,
		IWD_CLS_BIT_OP,
		IWD_CLS_LIT_CTL
	} iwd_class_t;

	// Literal and control layout
	typedef enum logic [2:0] {
		IWD_FMT_NONE,
		IWD_FMT_GENERAL,
		IWD_FMT_ABS,
		IWD_FMT_PAGE,
		IWD_FMT_BANK,
		IWD_FMT_REL,
		IWD_FMT_PTR,
		IWD_FMT_OPONLY
	} iwd_fmt_t;

	// Decoded operand fields
	typedef struct packed {
		iwd_class_t cls;
		iwd_fmt_t fmt;
		logic [6:0] file_addr;
		logic dest_file;
		logic [2:0] bit_index;
		logic [7:0] lit8;
		logic [10:0] lit11;
		logic [6:0] lit7;
		logic [4:0] lit5;
		logic [8:0] lit9;
		logic ptr_sel;
		logic uses_file;
		logic [1:0] cycles;
	} iwd_fields_t;
endpackage

// File: test/iwd_dec_assertions.sv
// Checker of decoder timing and fields.
// Assumes binding to iwd_decoder; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module iwd_dec_chk (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Watched ports
	input wire logic instr_valid_in,
	input wire logic instr_ready_out,
	input wire iwd_pkg::iwd_fields_t fields_out,
	input wire logic fields_valid_out,
	input wire logic cycle_stb_out,
	input wire logic busy_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Closed gaps before the next word may enter
	sequence shut3; !instr_ready_out [*3]; endsequence
	sequence shut7; !instr_ready_out [*7]; endsequence
	sequence shut8; !instr_ready_out [*8]; endsequence
	wire logic done = fields_valid_out; // Decode just landed
	stb_gap_a: assert property (
		cycle_stb_out |=> !cycle_stb_out [*3] ##1 cycle_stb_out) else $error("strobe gap");
	ready_stb_a: assert property (
		instr_ready_out |-> cycle_stb_out) else $error("ready off strobe");
	take_ans_a: assert property (
		instr_ready_out && instr_valid_in |=> done && busy_out) else $error("no answer");
	one_cyc_a: assert property (
		done && fields_out.cycles == 2'h1 |-> shut3 ##1 instr_ready_out) else $error("one");
	two_cyc_a: assert property (
		done && fields_out.cycles == 2'h2 |-> shut7 ##1 instr_ready_out) else $error("two");
	three_cyc_a: assert property (
		done && fields_out.cycles == 2'h3 |-> shut8 ##1 shut3 ##1 instr_ready_out) else $error("three");
	dest_file_a: assert property (
		done && fields_out.cls != iwd_pkg::IWD_CLS_BYTE_OP |-> fields_out.dest_file)
		else $error("dest bit");
	rmw_read_a: assert property (
		done |-> fields_out.uses_file == (fields_out.cls != iwd_pkg::IWD_CLS_LIT_CTL))
		else $error("read flag");
endmodule
bind iwd_decoder iwd_dec_chk iwd_dec_chk_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .fields_out(fields_out),
	.fields_valid_out(fields_valid_out), .cycle_stb_out(cycle_stb_out), .busy_out(busy_out));
`default_nettype wire

// File: test/iwd_pm.sv
// Program memory model handing queued words to the decoder.
// Assumes the bench fills q; slow_in adds stalls between words.
`timescale 1ns/1ns
`default_nettype none
module iwd_pm (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Stall request and handshake
	input wire logic slow_in,
	input wire logic ready_in,
	// Word to the decoder
	output logic [13:0] word_out,
	output logic valid_out
);
	logic [13:0] q[$]; // Words to send
	int gap = 0; // Stall cycles left
	initial {valid_out, word_out} = 15'h0000;
	// Hold a word until taken; idle word toggles so stale data never matches
	always @(posedge core_clk_in) begin
		if (valid_out && ready_in) begin
			void'(q.pop_front());
			gap = slow_in ? 3 : 0;
		end
		if (gap > 0) gap--;
		if (!rst_b_in || gap > 0 || q.size() == 0) begin
			valid_out <= #1 1'b0;
			word_out <= #1 ~word_out;
		end else begin
			valid_out <= #1 1'b1;
			word_out <= #1 q[0];
		end
	end
endmodule
`default_nettype wire

// File: test/tb_instr_word_decode_timing.sv
// Bench: corner and random words through the decoder, fields checked.
// Assumes iwd_pm and the bound checker are compiled in.
`timescale 1ns/1ns
`default_nettype none
module tb_instr_word_decode_timing;
	// Nets and bench state
	logic core_clk_in, rst_b_in, instr_valid_in, instr_ready_out, slow, rnd;
	logic fields_valid_out, cycle_stb_out, busy_out;
	logic [13:0] instr_word_in, w;
	logic [1:0] ptr_in_progmem_in;
	logic [15:0] e;
	logic [31:0] kk;
	iwd_pkg::iwd_fields_t fields_out;
	int miscompares = 0, checked = 0, cyc = 0;
	logic [15:0] pend[$]; // Pointer bits and word of each take
	localparam iwd_pkg::iwd_class_t c_byte = iwd_pkg::IWD_CLS_BYTE_OP;
	localparam iwd_pkg::iwd_class_t c_bit = iwd_pkg::IWD_CLS_BIT_OP;
	localparam iwd_pkg::iwd_class_t c_lit = iwd_pkg::IWD_CLS_LIT_CTL;
	// Corners: returns, jumps, don't-care bits, skips, indirect words
	logic [13:0] corner[22] = '{14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h2123, 14'h2FFF,
		14'h33FF, 14'h3400, 14'h37FF, 14'h07D5, 14'h003F, 14'h0014, 14'h31C0, 14'h0B81,
		14'h0F00, 14'h1800, 14'h1C85, 14'h1000, 14'h1385, 14'h0100, 14'h01FF, 14'h3FFF};
	iwd_decoder iwd_decoder_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.instr_word_in(instr_word_in), .instr_valid_in(instr_valid_in),
		.ptr_in_progmem_in(ptr_in_progmem_in), .instr_ready_out(instr_ready_out),
		.fields_out(fields_out), .fields_valid_out(fields_valid_out),
		.cycle_stb_out(cycle_stb_out), .busy_out(busy_out));
	iwd_pm iwd_pm_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .slow_in(slow),
		.ready_in(instr_ready_out), .word_out(instr_word_in), .valid_out(instr_valid_in));
	// Expected class from the word alone
	function automatic iwd_pkg::iwd_class_t cls_of(logic [13:0] x);
		if (x[13:7] == 7'h0F || x[13:7] == 7'h31 || x[13] || (!x[12] && x[11:8] == 4'h0))
			return c_lit;
		return x[12] ? c_bit : c_byte;
	endfunction
	// Expected cycles: two for flow changes, one more for indirect into program memory
	function automatic logic [1:0] cyc_of(logic [13:0] x, logic [1:0] p);
		logic two;
		two = x[13:12] == 2'h2 || x[13:9] == 5'h19 || x[13:10] == 4'hD || x[13:2] == 12'h002
			|| (cls_of(x) == c_bit && x[11]) || x[13:8] == 6'h0B || x[13:8] == 6'h0F;
		return 2'h1 + 2'(two) + 2'(cls_of(x) != c_lit && x[6:1] == 6'h00 && p[x[0]]);
	endfunction
	// Expected layout of the literal-and-control words; file words carry none
	function automatic iwd_pkg::iwd_fmt_t fmt_of(logic [13:0] x);
		if (x[13:12] == 2'h2) return iwd_pkg::IWD_FMT_ABS;
		if (x[13:9] == 5'h19) return iwd_pkg::IWD_FMT_REL;
		if (x[13:7] == 7'h0F) return iwd_pkg::IWD_FMT_PAGE;
		if (x[13:5] == 9'h001) return iwd_pkg::IWD_FMT_BANK;
		if (x[13:3] == 11'h002 || x[13:7] == 7'h31) return iwd_pkg::IWD_FMT_PTR;
		if (x[13]) return iwd_pkg::IWD_FMT_GENERAL;
		return (cls_of(x) == c_lit) ? iwd_pkg::IWD_FMT_OPONLY : iwd_pkg::IWD_FMT_NONE;
	endfunction
	// Expected and seen operand field of the word's layout
	function automatic logic [31:0] keys(logic [13:0] x, iwd_pkg::iwd_fields_t f);
		if (cls_of(x) == c_byte) return {8'h00, x[7:0], 8'h00, f.dest_file, f.file_addr};
		if (cls_of(x) == c_bit) return {6'h00, x[9:0], 6'h00, f.bit_index, f.file_addr};
		if (x[13:12] == 2'h2) return {5'h00, x[10:0], 5'h00, f.lit11};
		if (x[13:9] == 5'h19) return {7'h00, x[8:0], 7'h00, f.lit9};
		if (x[13:7] == 7'h0F) return {9'h000, x[6:0], 9'h000, f.lit7};
		if (x[13:5] == 9'h001) return {11'h000, x[4:0], 11'h000, f.lit5};
		if (x[13:3] == 11'h002) return {15'h0000, x[2], 15'h0000, f.ptr_sel};
		if (x[13:7] == 7'h31) return {15'h0000, x[6], 15'h0000, f.ptr_sel};
		return x[13] ? {8'h00, x[7:0], 8'h00, f.lit8} : 32'h0000_0000;
	endfunction
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Wait until the model is empty and the last instruction has run out
	task automatic drain();
		while (iwd_pm_i.q.size() != 0) @(posedge core_clk_in);
		repeat (16) @(posedge core_clk_in);
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	// Random pointer targets and stalls once the random phase starts
	always @(posedge core_clk_in) begin
		#1;
		if (rnd) begin
			ptr_in_progmem_in = 2'($urandom);
			slow = 1'($urandom);
		end
	end
	// Hang guard, well above the expected run
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	// Scoreboard: compare at the answer, record at the take
	always @(negedge core_clk_in) begin
		if (fields_valid_out === 1'b1 && pend.size() != 0) begin
			e = pend.pop_front();
			check("class", 16'(cls_of(e[13:0])), 16'(fields_out.cls));
			check("format", 16'(fmt_of(e[13:0])), 16'(fields_out.fmt));
			check("cycles", 16'(cyc_of(e[13:0], e[15:14])), 16'(fields_out.cycles));
			kk = keys(e[13:0], fields_out);
			check("field", kk[31:16], kk[15:0]);
		end
		if (instr_ready_out === 1'b1 && instr_valid_in === 1'b1)
			pend.push_back({ptr_in_progmem_in, instr_word_in});
	end
	initial begin
		rst_b_in = 1'b0;
		ptr_in_progmem_in = 2'h3;
		slow = 1'b0;
		rnd = 1'b0;
		w = 14'($urandom(31));
		repeat (12) @(posedge core_clk_in);
		#1 rst_b_in = 1'b1;
		foreach (corner[i]) iwd_pm_i.q.push_back(corner[i]);
		drain();
		rnd = 1'b1;
		// Overlapping page and pointer-offset layouts are kept out; the corner table holds a page word only
		repeat (300) begin
			w = 14'($urandom);
			while (w[13:7] == 7'h0F || w[13:7] == 7'h31) w = 14'($urandom);
			iwd_pm_i.q.push_back(w);
		end
		drain();
		check("pending", 16'h0000, 16'(pend.size()));
		end_of_test();
	end
endmodule
`default_nettype wire
